// ---- include/key_builder_map.svh ----
`ifndef KEY_BUILDER_MAP_SVH
`define KEY_BUILDER_MAP_SVH

// ********************************
// Register offsets
// ********************************
`define REG_CTRL 12'h000
`define REG_PORT 12'h004
`define REG_KEY_TYPE 12'h008
`define REG_RANGE_KIND 12'h00c
`define REG_STATUS 12'h010
`define REG_RANGE_BASE 12'h020
`define REG_RANGE_LAST 12'h03c

// ********************************
// Field positions
// ********************************
`define CTRL_DSCP_BIT 0
`define CTRL_GDEF_LSB 2
`define STATUS_TYPE_LSB 16
`define RANGE_HIGH_LSB 16

// ********************************
// Reset values
// ********************************
`define CTRL_RST 3'h0
`define PORT_RST 6'h00
`define KEY_TYPE_RST 4'h5
`define RANGE_KIND_RST 24'hffffff
`define RANGE_BOUND_RST 32'h00000000

// ********************************
// Frame geometry
// ********************************
`define NUM_RANGES 8
`define WIN_BYTES 64
`define ETH_BASE_LEN 7'h0e
`define VLAN_TAG_LEN 7'h04
`define IP_PAYLOAD_OFS 7'h14
`define CUSTOM_BYTES 15

`endif

// ---- include/key_builder_pkg.sv ----
package key_builder_pkg;
    typedef enum logic [1:0] {low_latency_full_key, normal_key, normal_ipv4_tuple_key, custom_2_key} wide_key_t;
    typedef enum logic [1:0] {idx_ctrl_default, idx_ctrl_value, idx_ctrl_service} idx_ctrl_t;
    typedef enum logic [1:0] {gdef_zero, gdef_lport, gdef_masq} gdef_sel_t;
    typedef enum logic [2:0] {rng_sport, rng_dport, rng_either, rng_vid, rng_dscp, rng_custom, rng_off} range_kind_t;
endpackage

// ---- verilog/range_checker.sv ----
`timescale 1ns/10ps
module range_checker
    import key_builder_pkg::*;
(
    input wire logic [2:0] kind,
    input wire logic [15:0] low,
    input wire logic [15:0] high,
    input wire logic [15:0] src_port,
    input wire logic [15:0] dst_port,
    input wire logic [11:0] vid,
    input wire logic [5:0] dscp,
    input wire logic [15:0] custom,
    output logic hit
);
    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    always_comb
    begin
        hit = 1'b0;
        case (kind)
            rng_sport: hit = in_range(src_port, low, high);
            rng_dport: hit = in_range(dst_port, low, high);
            rng_either: hit = in_range(src_port, low, high) || in_range(dst_port, low, high);
            rng_vid: hit = in_range({4'h0, vid}, low, high);
            // Remapped DSCP arrives on this port, not the frame's own
            rng_dscp: hit = in_range({10'h000, dscp}, low, high);
            rng_custom: hit = in_range(custom, low, high);
            default: hit = 1'b0;
        endcase
    end
endmodule

// ---- verilog/classifier_key_builder.sv ----
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "key_builder_map.svh"
module classifier_key_builder
    import key_builder_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_valid,
    input wire logic lookup_first,
    input wire logic [5:0] frame_dscp,
    input wire logic [5:0] classified_dscp,
    input wire logic [5:0] remapped_dscp,
    input wire logic ethertype_flag,
    input wire logic ip_or_snap_flag,
    input wire logic ipv4_flag,
    input wire logic frame_is_eth,
    input wire logic [1:0] vlan_tag_count,
    input wire logic [31:0] ipv4_dst_addr,
    input wire logic [31:0] ipv6_dst_addr_low,
    input wire logic [31:0] ipv4_src_addr,
    input wire logic [31:0] ipv6_src_addr_low,
    input wire logic [7:0] llc_ctrl_byte,
    input wire logic [23:0] snap_pid,
    input wire logic [31:0] l2_payload_word,
    input wire logic [7:0] ipv4_protocol,
    input wire logic [7:0] ipv6_next_header,
    input wire logic [15:0] l4_src_port,
    input wire logic [15:0] l4_dst_port,
    input wire logic [11:0] frame_vid,
    input wire logic [15:0] range_custom_value,
    input wire logic [5:0] ip_header_offset,
    input wire logic [5:0] frame_pointer,
    input wire logic [511:0] frame_window,
    input wire logic prev_action_valid,
    input wire logic [1:0] next_index_control,
    input wire logic [11:0] next_index_value,
    input wire logic [11:0] service_index,
    input wire logic [5:0] masq_port_number,
    output logic key_valid,
    output logic [5:0] dscp_key_field,
    output logic [31:0] dest_addr_key_field,
    output logic [31:0] overloaded_src_key_field,
    output logic [7:0] protocol_key_field,
    output logic [7:0] range_mask_field,
    output logic [31:0] ip_payload_word_field,
    output logic [119:0] custom_payload_field,
    output logic [1:0] wide_key_type_selector,
    output logic lookup_first_flag,
    output logic [5:0] ingress_port_field,
    output logic chain_index_service_flag,
    output logic [11:0] generic_chain_index
);
    // ********************************
    // Helpers
    // ********************************
    // Bytes beyond the captured window read as zero rather than wrapping
    function automatic logic [7:0] win_byte(input logic [511:0] w, input logic [6:0] idx);
        if (idx >= 7'(`WIN_BYTES))
        begin
            win_byte = 8'h00;
        end
        else
        begin
            win_byte = w[{idx[5:0], 3'b000} +: 8];
        end
    endfunction

    function automatic logic [31:0] win_word(input logic [511:0] w, input logic [6:0] idx);
        win_word = {win_byte(w, idx), win_byte(w, 7'(idx + 7'h01)),
                    win_byte(w, 7'(idx + 7'h02)), win_byte(w, 7'(idx + 7'h03))};
    endfunction

    function automatic logic [11:0] port_to_idx(input logic [5:0] p);
        port_to_idx = {6'h00, p};
    endfunction

    // ********************************
    // Configuration registers
    // ********************************
    logic use_classified_dscp_enable;
    logic [1:0] chain_index_default_select;
    logic [5:0] logical_port_number;
    logic [3:0] key_type_q;
    logic [23:0] range_kind_q;
    logic [31:0] range_bound_q [`NUM_RANGES];
    logic [15:0] key_count_q;
    logic [1:0] last_type_q;

    logic setup_phase;
    logic access_done;
    logic wr_en;
    logic addr_ok;
    logic range_hit;
    logic [2:0] range_sel;
    logic [31:0] rd_d;

    assign setup_phase = psel && !penable && !pready;
    assign access_done = psel && penable && pready;
    assign wr_en = access_done && pwrite && !pslverr;
    assign range_hit = (paddr >= `REG_RANGE_BASE) && (paddr <= `REG_RANGE_LAST) && (paddr[1:0] == 2'h0);
    assign range_sel = paddr[4:2];

    always_comb
    begin
        addr_ok = 1'b1;
        rd_d = 32'h00000000;
        if (range_hit)
        begin
            rd_d = range_bound_q[range_sel];
        end
        else
        begin
            unique case (paddr)
                `REG_CTRL: rd_d = {28'h0, chain_index_default_select, 1'b0, use_classified_dscp_enable};
                `REG_PORT: rd_d = {26'h0, logical_port_number};
                `REG_KEY_TYPE: rd_d = {28'h0, key_type_q};
                `REG_RANGE_KIND: rd_d = {8'h00, range_kind_q};
                `REG_STATUS: rd_d = {14'h0, last_type_q, key_count_q};
                default: addr_ok = 1'b0;
            endcase
        end
    end

    // One wait-free access cycle: the answer is prepared at the setup edge
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else if (setup_phase)
        begin
            pready <= 1'b1;
            pslverr <= !addr_ok;
            prdata <= (pwrite || !addr_ok) ? 32'h00000000 : rd_d;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            use_classified_dscp_enable <= 1'b0;
            chain_index_default_select <= 2'h0;
            logical_port_number <= `PORT_RST;
            key_type_q <= `KEY_TYPE_RST;
            range_kind_q <= `RANGE_KIND_RST;
        end
        else if (wr_en)
        begin
            if (paddr == `REG_CTRL)
            begin
                use_classified_dscp_enable <= pwdata[`CTRL_DSCP_BIT];
                chain_index_default_select <= pwdata[`CTRL_GDEF_LSB +: 2];
            end
            if (paddr == `REG_PORT)
            begin
                logical_port_number <= pwdata[5:0];
            end
            if (paddr == `REG_KEY_TYPE)
            begin
                key_type_q <= pwdata[3:0];
            end
            if (paddr == `REG_RANGE_KIND)
            begin
                range_kind_q <= pwdata[23:0];
            end
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < `NUM_RANGES; i++)
            begin
                range_bound_q[i] <= `RANGE_BOUND_RST;
            end
        end
        else if (wr_en && range_hit)
        begin
            range_bound_q[range_sel] <= pwdata;
        end
    end

    // ********************************
    // Range checkers
    // ********************************
    logic [7:0] range_hits;

    for (genvar g = 0; g < `NUM_RANGES; g++)
    begin : gen_rng
        range_checker u_rng (
            .kind(range_kind_q[3*g +: 3]),
            .low(range_bound_q[g][15:0]),
            .high(range_bound_q[g][`RANGE_HIGH_LSB +: 16]),
            .src_port(l4_src_port),
            .dst_port(l4_dst_port),
            .vid(frame_vid),
            .dscp(remapped_dscp),
            .custom(range_custom_value),
            .hit(range_hits[g])
        );
    end

    // ********************************
    // Field selection
    // ********************************
    logic [31:0] src_d;
    logic [6:0] custom_base;
    logic [6:0] eth_len;
    logic [119:0] custom_d;
    wide_key_t key_type;
    logic [11:0] gidx_d;
    logic service_d;
    logic [11:0] gidx_default;

    always_comb
    begin
        src_d = l2_payload_word;
        if (!ethertype_flag && !ip_or_snap_flag)
        begin
            src_d = {llc_ctrl_byte, l2_payload_word[31:8]};
        end
        else if (!ethertype_flag)
        begin
            src_d = {snap_pid, l2_payload_word[31:24]};
        end
        else if (ip_or_snap_flag)
        begin
            src_d = ipv4_flag ? ipv4_src_addr : ipv6_src_addr_low;
        end
    end

    // Tag count is at most three, so the header length never leaves seven bits
    assign eth_len = `ETH_BASE_LEN + 7'({vlan_tag_count, 2'b00});
    assign custom_base = frame_is_eth ? 7'(eth_len + {1'b0, frame_pointer}) : {1'b0, frame_pointer};

    always_comb
    begin
        custom_d = 120'h0;
        for (int i = 0; i < `CUSTOM_BYTES; i++)
        begin
            custom_d[8*(`CUSTOM_BYTES-1-i) +: 8] = win_byte(frame_window, 7'(custom_base + 7'(i)));
        end
    end

    assign key_type = lookup_first ? wide_key_t'(key_type_q[1:0]) : wide_key_t'(key_type_q[3:2]);

    always_comb
    begin
        gidx_default = 12'h000;
        case (gdef_sel_t'(chain_index_default_select))
            gdef_lport: gidx_default = port_to_idx(logical_port_number);
            gdef_masq: gidx_default = port_to_idx(masq_port_number);
            default: gidx_default = 12'h000;
        endcase
    end

    // Reserved control codes fall back to the default so a stale action cannot bind entries
    always_comb
    begin
        gidx_d = gidx_default;
        service_d = 1'b0;
        if (prev_action_valid)
        begin
            case (idx_ctrl_t'(next_index_control))
                idx_ctrl_value: gidx_d = next_index_value;
                idx_ctrl_service:
                begin
                    gidx_d = service_index;
                    service_d = 1'b1;
                end
                default: gidx_d = gidx_default;
            endcase
        end
    end

    // ********************************
    // Key output registers
    // ********************************
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            key_valid <= 1'b0;
        end
        else
        begin
            key_valid <= frame_valid;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            dscp_key_field <= 6'h00;
            dest_addr_key_field <= 32'h00000000;
            overloaded_src_key_field <= 32'h00000000;
            protocol_key_field <= 8'h00;
            range_mask_field <= 8'h00;
            ip_payload_word_field <= 32'h00000000;
            custom_payload_field <= 120'h0;
        end
        else if (frame_valid)
        begin
            dscp_key_field <= use_classified_dscp_enable ? classified_dscp : frame_dscp;
            dest_addr_key_field <= ipv4_flag ? ipv4_dst_addr : ipv6_dst_addr_low;
            overloaded_src_key_field <= src_d;
            protocol_key_field <= ipv4_flag ? ipv4_protocol : ipv6_next_header;
            range_mask_field <= range_hits;
            ip_payload_word_field <= win_word(frame_window, 7'({1'b0, ip_header_offset} + `IP_PAYLOAD_OFS));
            custom_payload_field <= custom_d;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            wide_key_type_selector <= 2'h0;
            lookup_first_flag <= 1'b0;
            ingress_port_field <= 6'h00;
            chain_index_service_flag <= 1'b0;
            generic_chain_index <= 12'h000;
        end
        else if (frame_valid)
        begin
            wide_key_type_selector <= key_type;
            lookup_first_flag <= lookup_first;
            if (key_type == low_latency_full_key)
            begin
                ingress_port_field <= logical_port_number;
                chain_index_service_flag <= 1'b0;
                generic_chain_index <= 12'h000;
            end
            else
            begin
                ingress_port_field <= 6'h00;
                chain_index_service_flag <= service_d;
                generic_chain_index <= gidx_d;
            end
        end
    end

    // ********************************
    // Status
    // ********************************
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            key_count_q <= 16'h0000;
            last_type_q <= 2'h0;
        end
        else if (frame_valid)
        begin
            key_count_q <= key_count_q + 16'h0001;
            last_type_q <= key_type;
        end
    end
endmodule

// ---- dv/key_builder_chk.sv ----
`timescale 1ns/10ps
module key_builder_chk
    import key_builder_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frame_valid,
    input wire logic lookup_first,
    input wire logic ipv4_flag,
    input wire logic [31:0] ipv4_dst_addr,
    input wire logic [31:0] ipv6_dst_addr_low,
    input wire logic [7:0] ipv4_protocol,
    input wire logic [7:0] ipv6_next_header,
    input wire logic prev_action_valid,
    input wire logic [1:0] next_index_control,
    input wire logic [11:0] next_index_value,
    input wire logic [11:0] service_index,
    input wire logic key_valid,
    input wire logic [31:0] dest_addr_key_field,
    input wire logic [7:0] protocol_key_field,
    input wire logic [1:0] wide_key_type_selector,
    input wire logic lookup_first_flag,
    input wire logic [5:0] ingress_port_field,
    input wire logic chain_index_service_flag,
    input wire logic [11:0] generic_chain_index
);
    // ********
    // Key and bus timing
    // ********
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence s_setup;
        psel && !penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    sequence s_wide;
        key_valid && wide_key_type_selector != low_latency_full_key;
    endsequence

    AST_APB_ANSWER: assert property (s_setup |=> s_answer)
        else $error("apb answer not exactly one cycle after setup");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("slave error outside the answer cycle");
    AST_KEY_PULSE: assert property (frame_valid |=> key_valid)
        else $error("key not built one cycle after frame");
    AST_KEY_IDLE: assert property (!frame_valid |=> !key_valid && $stable(generic_chain_index))
        else $error("key changed without a frame");
    AST_DEST: assert property (frame_valid |=> dest_addr_key_field == $past(ipv4_flag ? ipv4_dst_addr : ipv6_dst_addr_low))
        else $error("destination field wrong");
    AST_PROTO: assert property (frame_valid |=> protocol_key_field == $past(ipv4_flag ? ipv4_protocol : ipv6_next_header))
        else $error("protocol field wrong");
    AST_FIRST: assert property (frame_valid |=> lookup_first_flag == $past(lookup_first))
        else $error("lookup order flag wrong");
    AST_LL_NO_INDEX: assert property (key_valid && wide_key_type_selector == low_latency_full_key |-> !chain_index_service_flag && generic_chain_index == 12'h000)
        else $error("index present in low latency key");
    AST_WIDE_NO_PORT: assert property (s_wide |-> ingress_port_field == 6'h00)
        else $error("ingress port present in wide key");
    AST_SERVICE_FLAG: assert property (s_wide |-> chain_index_service_flag == $past(prev_action_valid && next_index_control == 2'h2))
        else $error("service flag wrong");
    AST_INDEX_VALUE: assert property (s_wide ##0 $past(prev_action_valid && next_index_control == 2'h1) |-> generic_chain_index == $past(next_index_value))
        else $error("chained index wrong");
    AST_INDEX_SERVICE: assert property (s_wide ##0 chain_index_service_flag |-> generic_chain_index == $past(service_index))
        else $error("service index not used");
endmodule
bind classifier_key_builder key_builder_chk chk_u (.*);

// ---- dv/cam_lookup_model.sv ----
`timescale 1ns/10ps
module cam_lookup_model
    import key_builder_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic key_valid,
    input wire logic [1:0] wide_key_type_selector,
    output logic [15:0] key_count,
    output logic [1:0] last_type
);
    // Match stage only consumes keys; it never stalls the builder
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            key_count <= 16'h0000;
            last_type <= 2'h0;
        end
        else if (key_valid)
        begin
            key_count <= key_count + 16'h0001;
            last_type <= wide_key_type_selector;
        end
    end
endmodule

// ---- dv/classifier_key_builder_tb.sv ----
`timescale 1ns/10ps
`include "key_builder_map.svh"
module classifier_key_builder_tb;
    import key_builder_pkg::*;
    logic mclk = '0, reset = '1, psel = '0, penable = '0, pwrite = '0, frame_valid = '0, lookup_first = '1;
    logic ethertype_flag = '0, ip_or_snap_flag = '0, ipv4_flag = '0, frame_is_eth = '0, prev_action_valid = '0;
    logic [1:0] vlan_tag_count = '0, next_index_control = '0, wide_key_type_selector, last_type, lt;
    logic [5:0] frame_dscp = 6'h11, classified_dscp = 6'h2a, remapped_dscp = '0, masq_port_number = 6'h17;
    logic [5:0] ip_header_offset = '0, frame_pointer = '0, dscp_key_field, ingress_port_field;
    logic [7:0] llc_ctrl_byte = 8'h03, ipv4_protocol = 8'h06, ipv6_next_header = 8'h11;
    logic [11:0] paddr = '0, frame_vid = 12'h064, next_index_value = 12'h5a5, service_index = 12'h3c3;
    logic [15:0] l4_src_port = '0, l4_dst_port = 16'h0bb8, range_custom_value = 16'h0001, key_count, nf = '0;
    logic [23:0] snap_pid = 24'h00000c;
    logic [31:0] pwdata = '0, ipv4_dst_addr = 32'hc0a80001, ipv6_dst_addr_low = 32'hfe800002;
    logic [31:0] ipv4_src_addr = 32'h0a000001, ipv6_src_addr_low = 32'h20010db8, l2_payload_word = 32'h11223344;
    logic [31:0] prdata, dest_addr_key_field, overloaded_src_key_field, ip_payload_word_field;
    logic pready, pslverr, key_valid, lookup_first_flag, chain_index_service_flag;
    logic [7:0] protocol_key_field, range_mask_field;
    logic [119:0] custom_payload_field;
    logic [11:0] generic_chain_index;
    logic [511:0] frame_window;
    logic [32:0] r;
    int err_count = 0, check_count = 0;
    logic [2:0] ft [5] = '{3'h0, 3'h2, 3'h7, 3'h6, 3'h4};
    logic [31:0] fs [5] = '{32'h03112233, 32'h00000c11, 32'h0a000001, 32'h20010db8, 32'h11223344};
    logic [15:0] sp [3] = '{16'h0064, 16'h00c8, 16'h00c9};
    logic [5:0] rm [3] = '{6'h0a, 6'h0b, 6'h0a};
    logic [7:0] rx [3] = '{8'h37, 8'h35, 8'h3e};
    logic [5:0] io [4] = '{6'h05, 6'h2a, 6'h00, 6'h13};
    logic [5:0] fp [4] = '{6'h03, 6'h01, 6'h00, 6'h3a};
    logic [1:0] tg [4] = '{2'h0, 2'h2, 2'h3, 2'h0};

    classifier_key_builder dut_u (.*);
    cam_lookup_model far_u (.*);

    always #5 mclk = ~mclk;

    // ********
    // Bench tasks
    // ********
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        // Waits as long as the slave needs; only the watchdog ends a hang
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'h1);
        r = {pslverr, prdata};
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [32:0] exp);
        apb(1'h0, a, 32'h0);
        check(r, exp);
    endtask

    // key_valid is looked at on the falling edge so the launching edge has settled
    task automatic frame();
        frame_valid <= 1'h1;
        @(posedge mclk);
        frame_valid <= 1'h0;
        nf++;
        @(negedge mclk);
        check(key_valid, 1'h1);
        @(posedge mclk);
    endtask

    // Bytes past the window end read as zero
    function automatic logic [127:0] win(input int s, input int n);
        logic [127:0] v;
        v = '0;
        for (int k = 0; k < n; k++)
            v = {v[119:0], (s + k < 64) ? frame_window[8*(s+k) +: 8] : 8'h00};
        return v;
    endfunction

    task automatic conclude();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ********
    // Tests
    // ********
    initial
    begin
        for (int i = 0; i < 64; i++)
            frame_window[8*i +: 8] = 8'h80 + 8'(i);
        repeat (3) @(posedge mclk);
        reset <= 1'h0;
        @(posedge mclk);
        rchk(`REG_CTRL, 33'h0);
        rchk(`REG_KEY_TYPE, 33'h5);
        rchk(`REG_RANGE_KIND, 33'hffffff);
        rchk(12'h0fc, 33'h100000000);
        wr(`REG_STATUS, 32'hffffffff);
        rchk(`REG_STATUS, 33'h0);
        wr(`REG_PORT, 32'h2d);
        for (int s = 0; s < 4; s++)
        begin
            wr(`REG_CTRL, 32'(s * 5));
            frame();
            check(dscp_key_field, s[0] ? 6'h2a : 6'h11);
            check(generic_chain_index, s == 1 ? 12'h02d : s == 2 ? 12'h017 : 12'h000);
        end
        wr(`REG_CTRL, 32'h4);
        prev_action_valid <= 1'h1;
        next_index_control <= 2'h1;
        for (int t = 0; t < 8; t++)
        begin
            if (t[0] == 1'b0)
                wr(`REG_KEY_TYPE, 32'(t / 2 + 4 * (3 - t / 2)));
            lookup_first <= ~t[0];
            lt = t[0] ? 2'(3 - t / 2) : 2'(t / 2);
            frame();
            check(wide_key_type_selector, lt);
            check(lookup_first_flag, !t[0]);
            check(ingress_port_field, lt == 2'h0 ? 6'h2d : 6'h00);
            check(generic_chain_index, lt == 2'h0 ? 12'h000 : 12'h5a5);
        end
        lookup_first <= 1'h1;
        lt = 2'h3;
        for (int c = 0; c < 4; c++)
        begin
            next_index_control <= 2'(c);
            frame();
            check(chain_index_service_flag, c == 2);
            check(generic_chain_index, c == 1 ? 12'h5a5 : c == 2 ? 12'h3c3 : 12'h02d);
        end
        for (int i = 0; i < 5; i++)
        begin
            {ethertype_flag, ip_or_snap_flag, ipv4_flag} <= ft[i];
            frame();
            check(overloaded_src_key_field, fs[i]);
            check(dest_addr_key_field, ft[i][0] ? 32'hc0a80001 : 32'hfe800002);
            check(protocol_key_field, ft[i][0] ? 8'h06 : 8'h11);
        end
        // Checkers: sport, dscp, dport, either, vid, custom, then two off
        wr(`REG_RANGE_KIND, 32'hdab460);
        wr(`REG_RANGE_BASE, 32'h00c80064);
        wr(`REG_RANGE_BASE + 12'h004, 32'h000a000a);
        wr(`REG_RANGE_BASE + 12'h008, 32'h0bb80bb8);
        wr(`REG_RANGE_BASE + 12'h00c, 32'h00c900c9);
        wr(`REG_RANGE_BASE + 12'h010, 32'h00640064);
        wr(`REG_RANGE_BASE + 12'h014, 32'h00010001);
        for (int j = 0; j < 3; j++)
        begin
            l4_src_port <= sp[j];
            remapped_dscp <= rm[j];
            frame();
            check(range_mask_field, rx[j]);
        end
        for (int k = 0; k < 4; k++)
        begin
            ip_header_offset <= io[k];
            frame_is_eth <= k[0] ^ k[1];
            vlan_tag_count <= tg[k];
            frame_pointer <= fp[k];
            frame();
            check(ip_payload_word_field, win(io[k] + 20, 4));
            check(custom_payload_field, win((k > 0 && k < 3) ? 14 + 4 * tg[k] + fp[k] : fp[k], 15));
        end
        rchk(`REG_STATUS, {15'h0, lt, nf});
        check(key_count, nf);
        check(last_type, lt);
        conclude();
    end

    initial
    begin
        #100000;
        err_count++;
        conclude();
    end
endmodule
